//--- rtl/measurement_irq_readout.sv
//
// Operation
// [RULE1] Each fresh result from a source sets that source's event flag.
// [RULE2] Flag bits: 3 frequency counter, 2 peak hold, 1 coarse ADC, 0 fine ADC.
// [RULE3] Each mask bit gates only its own flag; flags update regardless of mask.
// [RULE4] An enabled new event drives the interrupt low until status is read.
// [RULE5] Completing the status read returns the interrupt line high.
// [RULE6] Host treats a falling interrupt edge as a request and reads status.
// [RULE7] Host rechecks the line after status read; reads again if still low.
// [RULE8] Flags read-only, mask read/write, via the two-nibble register transfer.
// [RULE9] A source flag clears when its clear strobe falls after its result read.
// [RULE10] Six result registers: three 24-bit in 6 nibbles, three 16-bit in 4.
// [RULE11] Host writes to result registers are ignored.
// [RULE12] Host issues exact nibble counts; cycle counter clears while ALE high.
// [RULE13] Host holds ADC first read strobe over one sample period, others over 2 us.
// [RULE14] Time-base read leaves bit 3 set; signal counter read clears it.
// [RULE15] Reading either peak register clears bit 2.
// [RULE16] 8-bit transfer is upper nibble then lower; new ALE restarts at upper.
// [RULE17] Event in the same cycle as its clear keeps the flag set.
//
`timescale 1ns/1ps
module measurement_irq_readout
  import irq_readout_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Microprocessor nibble bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic [3:0] ad_in,
  output logic [3:0] ad_out,
  output logic ad_oe,
  // Interrupt to the host, active low
  output logic interrupt_request_out_n,
  // Measurement sources, same clock domain
  input wire meas_in_t meas,
  // Flag state for observation
  output logic [3:0] event_flags
);

  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  bus_pins_t pins;
  bus_pins_t pins_raw;

  assign pins_raw = '{ale: ale, cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, ad: ad_in};

  nibble_sync #(
    .W($bits(bus_pins_t))
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d_in(pins_raw),
    .q(pins)
  );

  // ************************************************************
  // Event flags
  // ************************************************************
  core_state_t state_r;
  core_state_t state_nxt;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic [3:0] flags;

  always_comb
  begin
    ev_set = 4'h0;
    ev_set[FLAG_FREQ] = meas.freq_valid; // [RULE2]
    ev_set[FLAG_PEAK] = meas.peak_valid; // [RULE2]
    ev_set[FLAG_COARSE] = meas.coarse_valid; // [RULE2]
    ev_set[FLAG_FINE] = meas.fine_valid; // [RULE2]
  end

  // Clear on the falling edge of each source's strobe
  assign ev_clr = state_r.clr_strobe & ~state_nxt.clr_strobe; // [RULE9]

  event_flag_bank #(
    .N(NUM_FLAGS)
  ) u_flags (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .set(ev_set),
    .clr(ev_clr),
    .flags(flags)
  );

  // ************************************************************
  // Register images and transfer lengths
  // ************************************************************
  function automatic logic [2:0] nib_count(input logic [3:0] a);
    case (a)
      ADDR_TIME_BASE, ADDR_SIGNAL, ADDR_FINE: nib_count = NIB_LONG; // [RULE10]
      ADDR_POS_PEAK, ADDR_NEG_PEAK, ADDR_COARSE: nib_count = NIB_SHORT; // [RULE10]
      default: nib_count = NIB_INT; // [RULE16]
    endcase
  endfunction

  // Left aligned so the upper nibble always goes out first
  function automatic logic [23:0] reg_image(input core_state_t s, input logic [3:0] f);
    case (s.addr)
      ADDR_INT_REG: reg_image = {f, s.mask, 16'h0000}; // [RULE8]
      ADDR_TIME_BASE: reg_image = s.time_base;
      ADDR_SIGNAL: reg_image = s.signal;
      ADDR_POS_PEAK: reg_image = {s.pos_peak, 8'h00};
      ADDR_NEG_PEAK: reg_image = {s.neg_peak, 8'h00};
      ADDR_COARSE: reg_image = {s.coarse, 8'h00};
      ADDR_FINE: reg_image = s.fine;
      default: reg_image = LONG_RST;
    endcase
  endfunction

  // Which flags a completed result read clears
  function automatic logic [3:0] clear_map(input logic [3:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (a)
      ADDR_TIME_BASE: m = 4'h0; // [RULE14]
      ADDR_SIGNAL: m[FLAG_FREQ] = 1'b1; // [RULE14]
      ADDR_POS_PEAK, ADDR_NEG_PEAK: m[FLAG_PEAK] = 1'b1; // [RULE15]
      ADDR_COARSE: m[FLAG_COARSE] = 1'b1;
      ADDR_FINE: m[FLAG_FINE] = 1'b1;
      default: m = 4'h0;
    endcase
    clear_map = m;
  endfunction

  // ************************************************************
  // Bus engine
  // ************************************************************
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic [2:0] last_cyc;
  logic [23:0] image;
  logic status_done;

  assign rd_fall = state_r.prev.rd_n & ~pins.rd_n;
  assign rd_rise = ~state_r.prev.rd_n & pins.rd_n;
  assign wr_fall = state_r.prev.wr_n & ~pins.wr_n;
  assign wr_rise = ~state_r.prev.wr_n & pins.wr_n;
  assign last_cyc = 3'(nib_count(state_r.addr) - 3'h1);
  assign image = reg_image(state_r, flags);

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.prev = pins;
    status_done = 1'b0;

    // Result registers follow their sources
    if (meas.freq_valid)
    begin
      state_nxt.time_base = meas.time_base;
      state_nxt.signal = meas.signal;
    end
    if (meas.peak_valid)
    begin
      state_nxt.pos_peak = meas.pos_peak;
      state_nxt.neg_peak = meas.neg_peak;
    end
    if (meas.coarse_valid)
    begin
      state_nxt.coarse = meas.coarse;
    end
    if (meas.fine_valid)
    begin
      state_nxt.fine = meas.fine;
    end

    if (pins.ale)
    begin
      // Address latch also restarts the transfer at the upper nibble
      state_nxt.addr = pins.ad;
      state_nxt.cyc = CYC_RST; // [RULE12] [RULE16]
      state_nxt.phase = PH_IDLE;
      state_nxt.ad_oe = 1'b0;
      state_nxt.clr_strobe = 4'h0;
    end
    else if (pins.cs_n)
    begin
      state_nxt.phase = PH_IDLE;
      state_nxt.ad_oe = 1'b0;
    end
    else
    begin
      case (state_r.phase)
        PH_IDLE:
        begin
          if (rd_fall)
          begin
            state_nxt.phase = PH_READ;
            state_nxt.ad_oe = 1'b1;
            // Snapshot on the first nibble keeps a multi-nibble value coherent
            if (state_r.cyc == CYC_RST)
            begin
              state_nxt.ad_out = image[23:20]; // [RULE16]
              state_nxt.snap = {image[19:0], 4'h0};
            end
            else
            begin
              state_nxt.ad_out = state_r.snap[23:20];
              state_nxt.snap = {state_r.snap[19:0], 4'h0};
            end
            if (state_r.cyc == last_cyc)
            begin
              state_nxt.clr_strobe = clear_map(state_r.addr); // [RULE9]
            end
          end
          else if (wr_fall)
          begin
            state_nxt.phase = PH_WRITE;
          end
        end
        PH_READ:
        begin
          if (rd_rise)
          begin
            state_nxt.phase = PH_IDLE;
            state_nxt.ad_oe = 1'b0;
            state_nxt.clr_strobe = 4'h0; // [RULE9]
            if (state_r.addr == ADDR_INT_REG && state_r.cyc == last_cyc)
            begin
              status_done = 1'b1; // [RULE5]
            end
            // A surplus read holds at the last nibble
            if (state_r.cyc != last_cyc)
            begin
              state_nxt.cyc = 3'(state_r.cyc + 3'h1);
            end
          end
        end
        PH_WRITE:
        begin
          if (wr_rise)
          begin
            state_nxt.phase = PH_IDLE;
            // Only the lower nibble of the interrupt register is writable
            if (state_r.addr == ADDR_INT_REG && state_r.cyc == last_cyc)
            begin
              state_nxt.mask = pins.ad; // [RULE8] [RULE11]
            end
            if (state_r.cyc != last_cyc)
            begin
              state_nxt.cyc = 3'(state_r.cyc + 3'h1);
            end
          end
        end
        default:
        begin
          state_nxt.phase = PH_IDLE;
          state_nxt.ad_oe = 1'b0;
        end
      endcase
    end

    // ************************************************************
    // Interrupt line
    // ************************************************************
    // A new enabled event wins over the status read in the same cycle
    if (status_done)
    begin
      state_nxt.irq_pend = 1'b0; // [RULE5]
    end
    if (|(ev_set & state_r.mask))
    begin
      state_nxt.irq_pend = 1'b1; // [RULE3] [RULE4]
    end
    state_nxt.irq_n = ~state_nxt.irq_pend; // [RULE4]
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r.prev <= PINS_RST;
      state_r.phase <= PH_IDLE;
      state_r.addr <= NIB_RST;
      state_r.cyc <= CYC_RST;
      state_r.snap <= LONG_RST;
      state_r.mask <= MASK_RST;
      state_r.irq_pend <= 1'b0;
      state_r.irq_n <= 1'b1;
      state_r.ad_out <= NIB_RST;
      state_r.ad_oe <= 1'b0;
      state_r.clr_strobe <= FLAGS_RST;
      state_r.time_base <= LONG_RST;
      state_r.signal <= LONG_RST;
      state_r.pos_peak <= SHORT_RST;
      state_r.neg_peak <= SHORT_RST;
      state_r.coarse <= SHORT_RST;
      state_r.fine <= LONG_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign ad_out = state_r.ad_out;
  assign ad_oe = state_r.ad_oe;
  assign interrupt_request_out_n = state_r.irq_n;
  assign event_flags = flags;

endmodule

//--- rtl/irq_readout_pkg.sv
package irq_readout_pkg;

  // ************************************************************
  // Register addresses on the nibble bus
  // ************************************************************
  localparam logic [3:0] ADDR_INT_REG = 4'h9;
  localparam logic [3:0] ADDR_TIME_BASE = 4'hA;
  localparam logic [3:0] ADDR_SIGNAL = 4'hB;
  localparam logic [3:0] ADDR_POS_PEAK = 4'hC;
  localparam logic [3:0] ADDR_NEG_PEAK = 4'hD;
  localparam logic [3:0] ADDR_COARSE = 4'hE;
  localparam logic [3:0] ADDR_FINE = 4'hF;

  // ************************************************************
  // Nibble counts per transfer and flag positions
  // ************************************************************
  localparam logic [2:0] NIB_LONG = 3'h6;
  localparam logic [2:0] NIB_SHORT = 3'h4;
  localparam logic [2:0] NIB_INT = 3'h2;
  localparam int FLAG_FREQ = 3;
  localparam int FLAG_PEAK = 2;
  localparam int FLAG_COARSE = 1;
  localparam int FLAG_FINE = 0;
  localparam int NUM_FLAGS = 4;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [2:0] CYC_RST = 3'h0;
  localparam logic [23:0] LONG_RST = 24'h000000;
  localparam logic [15:0] SHORT_RST = 16'h0000;
  localparam logic [3:0] NIB_RST = 4'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_READ = 2'b01,
    PH_WRITE = 2'b10
  } bus_phase_t;

  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] ad;
  } bus_pins_t;

  localparam bus_pins_t PINS_RST = '{ale: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ad: 4'h0};

  typedef struct packed {
    logic freq_valid;
    logic [23:0] time_base;
    logic [23:0] signal;
    logic peak_valid;
    logic [15:0] pos_peak;
    logic [15:0] neg_peak;
    logic coarse_valid;
    logic [15:0] coarse;
    logic fine_valid;
    logic [23:0] fine;
  } meas_in_t;

  typedef struct packed {
    bus_pins_t prev;
    bus_phase_t phase;
    logic [3:0] addr;
    logic [2:0] cyc;
    logic [23:0] snap;
    logic [3:0] mask;
    logic irq_pend;
    logic irq_n;
    logic [3:0] ad_out;
    logic ad_oe;
    logic [3:0] clr_strobe;
    logic [23:0] time_base;
    logic [23:0] signal;
    logic [15:0] pos_peak;
    logic [15:0] neg_peak;
    logic [15:0] coarse;
    logic [23:0] fine;
  } core_state_t;

endpackage

//--- rtl/nibble_sync.sv
`timescale 1ns/1ps
module nibble_sync
  import irq_readout_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  // Idle levels so that the bus looks quiet coming out of reset
  localparam logic [W-1:0] IDLE_LVL = W'(PINS_RST);

  always_comb
  begin
    state_nxt.s1 = d_in;
    state_nxt.s2 = state_r.s1;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= '{s1: IDLE_LVL, s2: IDLE_LVL};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign q = state_r.s2;

endmodule

//--- rtl/event_flag_bank.sv
`timescale 1ns/1ps
module event_flag_bank
  import irq_readout_pkg::*;
#(
  parameter int N = NUM_FLAGS
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Per-source events and clears
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flags
);

  typedef struct packed {
    logic [N-1:0] flags;
  } bank_state_t;

  bank_state_t state_r;
  bank_state_t state_nxt;
  logic [N-1:0] flag_nxt;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_flag
      // Set beats clear so an event in the clearing cycle survives
      assign flag_nxt[i] = set[i] | (state_r.flags[i] & ~clr[i]); // [RULE1] [RULE9] [RULE17]
    end
  endgenerate

  always_comb
  begin
    state_nxt.flags = flag_nxt;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r.flags <= N'(FLAGS_RST);
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign flags = state_r.flags;

endmodule

//--- verification/measurement_irq_readout_monitor.sv
`timescale 1ns/1ps
module measurement_irq_readout_monitor
  import irq_readout_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic ale,
  input wire logic ad_oe,
  // Interrupt and flags
  input wire logic interrupt_request_out_n,
  input wire meas_in_t meas,
  input wire logic [3:0] event_flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ****************
  // Properties
  // ****************
  sequence s_rd_start;
    $fell(rd_n) && !cs_n && !ale;
  endsequence
  sequence s_oe_up;
    ##3 ad_oe;
  endsequence
  property p_set(v, f);
    v |=> f;
  endproperty
  a_freq_flag_set: assert property (p_set(meas.freq_valid, event_flags[3]))
    else $error("frequency flag not set");
  a_peak_flag_set: assert property (p_set(meas.peak_valid, event_flags[2]))
    else $error("peak flag not set");
  a_coarse_flag_set: assert property (p_set(meas.coarse_valid, event_flags[1]))
    else $error("coarse flag not set");
  a_fine_flag_set: assert property (p_set(meas.fine_valid, event_flags[0]))
    else $error("fine flag not set");
  a_irq_needs_event: assert property ($fell(interrupt_request_out_n) |->
    $past(meas.freq_valid | meas.peak_valid | meas.coarse_valid | meas.fine_valid))
    else $error("interrupt fell without event");
  a_irq_release_read: assert property ($rose(interrupt_request_out_n) |->
    $past(rd_n, 1) && $past(rd_n, 2))
    else $error("interrupt released outside status read end");
  a_flag_clear_read: assert property (|($past(event_flags) & ~event_flags) |->
    rd_n && $past(rd_n, 2))
    else $error("flag cleared outside read end");
  a_read_drive_on: assert property (s_rd_start |-> s_oe_up)
    else $error("read nibble not driven");
  a_idle_no_drive: assert property (rd_n [*4] |-> !ad_oe)
    else $error("bus driven while idle");
endmodule
bind measurement_irq_readout measurement_irq_readout_monitor u_mon (
  .ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .ale(ale), .ad_oe(ad_oe),
  .interrupt_request_out_n(interrupt_request_out_n), .meas(meas), .event_flags(event_flags)
);

//--- verification/nibble_host_model.sv
`timescale 1ns/1ps
module nibble_host_model
  import irq_readout_pkg::*;
#(
  parameter int SAMPLE_CYC = 500,
  parameter int SLOW_CYC = 401
)
(
  // Clock
  input wire logic ref_clk,
  // Bus pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic ale,
  output logic [3:0] ad_in,
  input wire logic [3:0] ad_out,
  input wire logic ad_oe,
  // Interrupt
  input wire logic interrupt_request_out_n
);
  logic [3:0] ad_h = 4'h0;
  // Shared AD lines: device wins while it drives, else host level
  assign ad_in = ad_oe ? ad_out : ad_h;
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ale = 1'b0;
  end
  task automatic latch(input logic [3:0] a);
    @(negedge ref_clk);
    cs_n = 1'b0;
    ad_h = a;
    ale = 1'b1;
    repeat (4) @(negedge ref_clk);
    ale = 1'b0;
    ad_h = ~a;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input int n, output logic [23:0] v);
    int lo;
    v = '0;
    latch(a);
    for (int i = 0; i < n; i++)
    begin
      // Slow strobes give the ADC time to settle its sample
      lo = (a == ADDR_COARSE || a == ADDR_FINE) ? (i == 0 ? SAMPLE_CYC : SLOW_CYC) : 6;
      rd_n = 1'b0;
      repeat (lo) @(negedge ref_clk);
      v = {v[19:0], ad_in};
      rd_n = 1'b1;
      repeat (6) @(negedge ref_clk);
    end
    cs_n = 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input int n, input logic [23:0] d);
    latch(a);
    for (int i = 0; i < n; i++)
    begin
      ad_h = d[(n - 1 - i) * 4 +: 4];
      wr_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      wr_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      ad_h = ~ad_h;
    end
    cs_n = 1'b1;
  endtask
  task automatic status(output logic [7:0] s);
    logic [23:0] v;
    rd(ADDR_INT_REG, 2, v);
    // A new edge may hide inside the read, so look again
    if (interrupt_request_out_n !== 1'b1)
    begin
      rd(ADDR_INT_REG, 2, v);
    end
    s = v[7:0];
  endtask
endmodule

//--- verification/measurement_irq_readout_tb_top.sv
`timescale 1ns/1ps
`define CMP(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("Error at %0t: got %0h exp %0h", $time, a, b); \
    end \
  end
module measurement_irq_readout_tb_top;
  import irq_readout_pkg::*;
  localparam logic [3:0] MASK = 4'h5;
  logic ref_clk = 1'b0;
  logic nrst, cs_n, rd_n, wr_n, ale, ad_oe, irq_n;
  logic [3:0] ad_in, ad_out, event_flags;
  logic [7:0] s;
  logic [23:0] got, e, v, x;
  logic [23:0] expq[$];
  logic [3:0] addr_t [6] = '{ADDR_TIME_BASE, ADDR_SIGNAL, ADDR_POS_PEAK, ADDR_NEG_PEAK,
    ADDR_COARSE, ADDR_FINE};
  int flag_t [6] = '{3, 3, 2, 2, 1, 0};
  meas_in_t meas;
  event got_ev;
  integer seed, fails, checks, cyc;
  always #2.5 ref_clk = ~ref_clk;
  measurement_irq_readout u_measurement_irq_readout (.ref_clk(ref_clk), .nrst(nrst),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .interrupt_request_out_n(irq_n), .meas(meas), .event_flags(event_flags));
  nibble_host_model u_nibble_host_model (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .ale(ale), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .interrupt_request_out_n(irq_n));
  // ****************
  // Checking
  // ****************
  task automatic chk(input logic [23:0] act, input logic [23:0] exp);
    expq.push_back(exp);
    got = act;
    -> got_ev;
    @(negedge ref_clk);
  endtask
  always @(got_ev)
  begin
    e = expq.pop_front();
    `CMP(got, e)
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails = fails + 1;
      results();
    end
  end
  // ****************
  // Stimulus
  // ****************
  task automatic fire(input int idx);
    logic [159:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    meas = r[$bits(meas_in_t)-1:0];
    meas.freq_valid = (idx == FLAG_FREQ);
    meas.peak_valid = (idx == FLAG_PEAK);
    meas.coarse_valid = (idx == FLAG_COARSE);
    meas.fine_valid = (idx == FLAG_FINE);
    @(negedge ref_clk);
    {meas.freq_valid, meas.peak_valid, meas.coarse_valid, meas.fine_valid} = 4'h0;
    @(negedge ref_clk);
  endtask
  function automatic logic [23:0] val(input logic [3:0] a);
    case (a)
      ADDR_TIME_BASE: val = meas.time_base;
      ADDR_SIGNAL: val = meas.signal;
      ADDR_POS_PEAK: val = {8'h00, meas.pos_peak};
      ADDR_NEG_PEAK: val = {8'h00, meas.neg_peak};
      ADDR_COARSE: val = {8'h00, meas.coarse};
      default: val = meas.fine;
    endcase
  endfunction
  initial
  begin
    seed = 32'hA8DA;
    fails = 0;
    checks = 0;
    cyc = 0;
    nrst = 1'b0;
    meas = '0;
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(24'(irq_n), 24'h1);
    u_nibble_host_model.rd(ADDR_INT_REG, 2, v);
    chk(v, 24'h0);
    // Upper nibble aims at the read-only flags and must be dropped
    u_nibble_host_model.wr(ADDR_INT_REG, 2, 24'({4'hF, MASK}));
    u_nibble_host_model.rd(ADDR_INT_REG, 2, v);
    chk(v, 24'(MASK));
    for (int k = 0; k < 6; k++)
    begin
      fire(flag_t[k]);
      chk(24'(event_flags), 24'(1 << flag_t[k]));
      chk(24'(irq_n), 24'(!MASK[flag_t[k]]));
      u_nibble_host_model.status(s);
      chk(24'(s), 24'({4'(1 << flag_t[k]), MASK}));
      chk(24'(irq_n), 24'h1);
      u_nibble_host_model.rd(addr_t[k], (flag_t[k] == 1 || flag_t[k] == 2) ? 4 : 6, v);
      chk(v, val(addr_t[k]));
      chk(24'(event_flags), (k == 0) ? 24'h8 : 24'h0);
    end
    // Abort a long read midway; the next address strobe restarts it
    fire(FLAG_FREQ);
    u_nibble_host_model.rd(ADDR_SIGNAL, 2, v);
    chk(v, 24'(meas.signal[23:16]));
    u_nibble_host_model.rd(ADDR_SIGNAL, 6, v);
    chk(v, meas.signal);
    // Enabled event lands after the status read ends, so the host must read again
    fork
      u_nibble_host_model.status(s);
      begin
        repeat (31) @(negedge ref_clk);
        fire(FLAG_FINE);
      end
    join
    chk(24'(s), 24'({4'h1, MASK}));
    chk(24'(irq_n), 24'h1);
    fire(FLAG_FINE);
    x = val(ADDR_FINE);
    u_nibble_host_model.wr(ADDR_FINE, 6, ~x);
    u_nibble_host_model.rd(ADDR_FINE, 6, v);
    chk(v, x);
    results();
  end
endmodule
